/* File: pch_cfg_decode.sv */
// Purpose: Read-data decode of the configuration header words
// Assumes: Combinational, same clock domain as the caller
// Notes: Every unlisted word reads as zero
`timescale 1ns/1ns
`default_nettype none
module pch_cfg_decode
  import pch_pkg::*;
(
  // Access address and live command value
  input wire logic [7:0] addr,
  input wire logic [15:0] cmd,
  // Decoded results
  output logic [31:0] rdata,
  output logic cmd_hit
);

  // ---------------------------------------------------------------
  // Word select
  // ---------------------------------------------------------------
  // Compare on the dword address only
  function automatic logic word_is(input logic [7:0] a, input logic [7:0] off);
    word_is = (a[7:2] == off[7:2]);
  endfunction

  // Read mux over implemented words
  always_comb begin
    rdata = 32'h00000000;
    if (word_is(addr, PCH_OFF_CMD)) begin
      rdata = {16'h0000, cmd};
    end else if (word_is(addr, PCH_OFF_CLASS)) begin
      rdata = {PCH_CLASS_VAL, PCH_REVISION_VAL};
    end else if (word_is(addr, PCH_OFF_CIS)) begin
      rdata = {PCH_CIS_IMAGE_VAL, PCH_CIS_OFFSET_VAL, PCH_CIS_SPACE_VAL};
    end else if (word_is(addr, PCH_OFF_CAP_PTR)) begin
      rdata = {24'h000000, PCH_CAP_PTR_VAL};
    end else if (word_is(addr, PCH_OFF_CAP_ID)) begin
      rdata = {24'h000000, PCH_CAP_ID_VAL};
    end
  end

  // Write hit on the command word
  assign cmd_hit = word_is(addr, PCH_OFF_CMD);

endmodule
`default_nettype wire

/* File: pch_config_header.sv */
// Purpose: Configuration header registers and the bus qualifiers they drive
// Assumes: Config cycles arrive already qualified by IDSEL, on the PCI clock
// Notes: Status, power management data and other header fields live elsewhere
`timescale 1ns/1ns
`default_nettype none
module pch_config_header
  import pch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration access, qualified by IDSEL
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en_n,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_claim_q,
  output logic [31:0] cfg_rdata_q,
  // Unit qualifiers
  input wire logic in_d0,
  input wire logic rom_window_enable,
  output logic [15:0] pci_command_control,
  output logic io_claim_en_q,
  output logic mem_claim_en_q,
  output logic rom_decode_en_q,
  // Card information window
  input wire logic cis_access,
  output logic cis_retry_q,
  // Bus master requests
  input wire logic pcix_mode,
  input wire logic master_req,
  input wire logic master_split,
  input wire logic mwi_wanted,
  output logic master_go_q,
  output logic mwi_select_q,
  // Parity and system error signalling
  input wire logic parity_event,
  input wire logic system_fault_event,
  output logic parity_report_q,
  output logic serr_out_q,
  output logic serr_oe_q
);

  // ---------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [31:0] rd_word;
  logic cmd_hit;
  logic initiator_en_q;
  logic [15:0] be_mask;

  assign pci_command_control = cmd_q;

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  pch_cfg_decode u_decode (
    .addr(cfg_addr),
    .cmd(cmd_q),
    .rdata(rd_word),
    .cmd_hit(cmd_hit)
  );

  // ---------------------------------------------------------------
  // Command register
  // ---------------------------------------------------------------
  // Byte lanes of the low half, low active enables
  assign be_mask = {{8{~cfg_byte_en_n[1]}}, {8{~cfg_byte_en_n[0]}}};

  // Merge written bits through lane and writable masks
  always_comb begin
    cmd_d = cmd_q;
    if (cfg_valid && cfg_write && cmd_hit) begin
      cmd_d = (cmd_q & ~(be_mask & PCH_CMD_WR_MASK)) |
              (cfg_wdata[15:0] & be_mask & PCH_CMD_WR_MASK);
    end
  end

  // Command storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= PCH_CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // ---------------------------------------------------------------
  // Configuration answer
  // ---------------------------------------------------------------
  // Claim every config cycle regardless of command value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_claim_q <= 1'b0;
    end else begin
      cfg_claim_q <= cfg_valid;
    end
  end

  // Read data captured with the claim, zero on writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata_q <= 32'h00000000;
    end else if (cfg_valid && !cfg_write) begin
      cfg_rdata_q <= rd_word;
    end else begin
      cfg_rdata_q <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Qualifiers
  // ---------------------------------------------------------------
  pch_enable_gate u_gate (
    .clk(clk),
    .resetn(resetn),
    .cmd(cmd_q),
    .in_d0(in_d0),
    .rom_window_enable(rom_window_enable),
    .io_claim_en_q(io_claim_en_q),
    .mem_claim_en_q(mem_claim_en_q),
    .rom_decode_en_q(rom_decode_en_q),
    .initiator_en_q(initiator_en_q)
  );

  // ---------------------------------------------------------------
  // Card information window
  // ---------------------------------------------------------------
  // Slow serial store behind it, so every access is retried while memory decode is enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cis_retry_q <= 1'b0;
    end else begin
      cis_retry_q <= cis_access & mem_claim_en_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus master permission
  // ---------------------------------------------------------------
  // Split completions in PCI-X mode bypass the master enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      master_go_q <= 1'b0;
    end else begin
      master_go_q <= master_req &
                     (initiator_en_q | (pcix_mode & master_split));
    end
  end

  // Memory write command choice for a granted request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mwi_select_q <= 1'b0;
    end else begin
      mwi_select_q <= master_req & initiator_en_q & mwi_wanted &
                      cmd_q[PCH_CMD_MWI];
    end
  end

  // ---------------------------------------------------------------
  // Error signalling
  // ---------------------------------------------------------------
  // Parity report only with response enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parity_report_q <= 1'b0;
    end else begin
      parity_report_q <= parity_event & cmd_q[PCH_CMD_PERR];
    end
  end

  // Open-drain system error: drive low only when enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serr_out_q <= 1'b0;
      serr_oe_q <= 1'b0;
    end else begin
      serr_out_q <= 1'b0;
      serr_oe_q <= system_fault_event & cmd_q[PCH_CMD_SERR];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Helper: read of a given word this cycle
  function automatic logic rd_of(input logic v, input logic w,
                                 input logic [7:0] a, input logic [7:0] off);
    rd_of = v & ~w & (a[7:2] == off[7:2]);
  endfunction

  a_cap_id_read:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CAP_ID)
    |=> cfg_claim_q && cfg_rdata_q == {24'h000000, PCH_CAP_ID_VAL})
    else $error("capability type code read wrong");

  a_cap_ptr_read:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CAP_PTR)
    |=> cfg_rdata_q[7:0] == PCH_CAP_PTR_VAL && cfg_rdata_q[31:8] == 24'h000000)
    else $error("capability list pointer read wrong");

  a_cis_word_read:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CIS)
    |=> cfg_rdata_q == PCH_CIS_VAL)
    else $error("card info pointer read wrong");

  a_cis_space_field:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CIS)
    |=> cfg_rdata_q[PCH_CIS_OFFSET_LSB-1:PCH_CIS_SPACE_LSB] == PCH_CIS_SPACE_VAL)
    else $error("info space select field wrong");

  a_cis_offset_field:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CIS)
    |=> cfg_rdata_q[PCH_CIS_IMAGE_LSB-1:PCH_CIS_OFFSET_LSB] == PCH_CIS_OFFSET_VAL)
    else $error("info byte offset field wrong");

  a_cis_image_field:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CIS)
    |=> cfg_rdata_q[31:PCH_CIS_IMAGE_LSB] == PCH_CIS_IMAGE_VAL)
    else $error("option image index field wrong");

  a_class_read:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_of(cfg_valid, cfg_write, cfg_addr, PCH_OFF_CLASS)
    |=> cfg_rdata_q[31:8] == PCH_CLASS_VAL)
    else $error("function class read wrong");

  a_cis_retry:
  assert property (@(posedge clk) disable iff (!resetn)
    cis_access && mem_claim_en_q |=> cis_retry_q)
    else $error("card info access not retried");

  a_cis_no_retry:
  assert property (@(posedge clk) disable iff (!resetn)
    cis_access && !mem_claim_en_q |=> !cis_retry_q)
    else $error("retry while memory decode off");

  a_zero_cmd_silent:
  assert property (@(posedge clk) disable iff (!resetn)
    cmd_q == 16'h0000 && $past(cmd_q) == 16'h0000 && !pcix_mode
    |=> !io_claim_en_q && !mem_claim_en_q && !rom_decode_en_q && !master_go_q)
    else $error("zero command still active");

  a_zero_cmd_config:
  assert property (@(posedge clk) disable iff (!resetn)
    cfg_valid && cmd_q == 16'h0000 |=> cfg_claim_q)
    else $error("config cycle not claimed");

  a_io_claim:
  assert property (@(posedge clk) disable iff (!resetn)
    ##1 io_claim_en_q == ($past(cmd_q[PCH_CMD_IO]) && $past(in_d0)))
    else $error("io claim enable wrong");

  a_rom_decode:
  assert property (@(posedge clk) disable iff (!resetn)
    cmd_q[PCH_CMD_MEM] && in_d0 && !rom_window_enable |=> !rom_decode_en_q)
    else $error("rom decode without window enable");

  a_master_d0:
  assert property (@(posedge clk) disable iff (!resetn)
    !in_d0 ##1 master_req && !pcix_mode |=> !master_go_q)
    else $error("mastering outside D0");

  a_mwi_select:
  assert property (@(posedge clk) disable iff (!resetn)
    mwi_select_q |-> $past(cmd_q[PCH_CMD_MWI]) && master_go_q)
    else $error("write-invalidate without permit");

  a_mwi_withheld:
  assert property (@(posedge clk) disable iff (!resetn)
    !cmd_q[PCH_CMD_MWI] |=> !mwi_select_q)
    else $error("write-invalidate while not permitted");

  a_parity_gate:
  assert property (@(posedge clk) disable iff (!resetn)
    parity_event |=> parity_report_q == $past(cmd_q[PCH_CMD_PERR]))
    else $error("parity report gating wrong");

  a_serr_hold:
  assert property (@(posedge clk) disable iff (!resetn)
    !cmd_q[PCH_CMD_SERR] [*2] |=> $stable(serr_oe_q) && !serr_out_q)
    else $error("system error moved while disabled");

  a_unmapped_zero:
  assert property (@(posedge clk) disable iff (!resetn)
    cfg_valid && !cfg_write && cfg_addr[7:2] == 6'h3f |=> cfg_rdata_q == 32'h00000000)
    else $error("unimplemented word not zero");

  a_no_claim_idle:
  assert property (@(posedge clk) disable iff (!resetn)
    !cfg_valid |=> !cfg_claim_q && cfg_rdata_q == 32'h00000000)
    else $error("claim without config cycle");

  a_reserved_zero:
  assert property (@(posedge clk) disable iff (!resetn)
    (cmd_q & ~PCH_CMD_WR_MASK) == 16'h0000)
    else $error("reserved command bit set");

  a_cmd_write:
  assert property (@(posedge clk) disable iff (!resetn)
    cfg_valid && cfg_write && cfg_addr[7:2] == PCH_OFF_CMD[7:2] && cfg_byte_en_n == 4'h0
    |=> cmd_q == ($past(cfg_wdata[15:0]) & PCH_CMD_WR_MASK))
    else $error("command write not taken");

endmodule
`default_nettype wire

/* File: pch_config_header_tb.sv */
// Purpose: Self-checking bench for the configuration header registers
// Assumes: Inputs change on the falling edge, outputs sampled there too
// Notes: Table of plain accesses first, then qualifier and reset cases
`timescale 1ns/1ns
`default_nettype none
module pch_config_header_tb;
  import pch_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_valid, cfg_write, cfg_claim_q;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en_n;
  logic [31:0] cfg_wdata, cfg_rdata_q;
  logic in_d0 = 1'b0, rom_window_enable = 1'b0, cis_access = 1'b0, pcix_mode = 1'b0;
  logic master_req = 1'b0, master_split = 1'b0, mwi_wanted = 1'b0;
  logic parity_event = 1'b0, system_fault_event = 1'b0;
  logic [15:0] pci_command_control;
  logic io_claim_en_q, mem_claim_en_q, rom_decode_en_q, cis_retry_q, master_go_q;
  logic mwi_select_q, parity_report_q, serr_out_q, serr_oe_q;
  logic cl, cl2;
  logic [31:0] rd, rd2;
  logic [5:0] kv;
  int failures = 0;
  int checked = 0;

  typedef struct packed {
    logic wr; logic [7:0] addr; logic [3:0] ben; logic [31:0] wd;
    logic [31:0] exp_rd; logic [15:0] exp_cmd;
  } pch_tb_row_s;
  localparam int NROWS = 18;
  pch_tb_row_s rows [NROWS] = '{
    '{1'b0, 8'h04, 4'h0, 32'h0, 32'h00000000, 16'h0000},
    '{1'b0, 8'h50, 4'h0, 32'h0, 32'h00000001, 16'h0000},
    '{1'b0, 8'h34, 4'h0, 32'h0, 32'h00000050, 16'h0000},
    '{1'b0, 8'h28, 4'h0, 32'h0, 32'h00000802, 16'h0000},
    '{1'b0, 8'h08, 4'h0, 32'h0, 32'h02000000, 16'h0000},
    '{1'b0, 8'h3c, 4'h0, 32'h0, 32'h00000000, 16'h0000},
    '{1'b0, 8'hfc, 4'h0, 32'h0, 32'h00000000, 16'h0000},
    '{1'b0, 8'h2b, 4'h0, 32'h0, 32'h00000802, 16'h0000},
    '{1'b1, 8'h28, 4'h0, 32'hffffffff, 32'h0, 16'h0000},
    '{1'b1, 8'h34, 4'h0, 32'hffffffff, 32'h0, 16'h0000},
    '{1'b1, 8'h50, 4'h0, 32'hffffffff, 32'h0, 16'h0000},
    '{1'b1, 8'h08, 4'h0, 32'hffffffff, 32'h0, 16'h0000},
    '{1'b0, 8'h28, 4'h0, 32'h0, 32'h00000802, 16'h0000},
    '{1'b0, 8'h08, 4'h0, 32'h0, 32'h02000000, 16'h0000},
    '{1'b1, 8'h04, 4'h0, 32'hffffffff, 32'h0, 16'h0157},
    '{1'b0, 8'h04, 4'h0, 32'h0, 32'h00000157, 16'h0157},
    '{1'b1, 8'h04, 4'he, 32'h0, 32'h0, 16'h0100},
    '{1'b1, 8'h04, 4'hd, 32'h0, 32'h0, 16'h0000}
  };

  // ------------------------------------------------------------
  // Clock, instances
  // ------------------------------------------------------------
  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  pch_host_model pch_host_model_i (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_byte_en_n(cfg_byte_en_n), .cfg_wdata(cfg_wdata),
    .cfg_claim_q(cfg_claim_q), .cfg_rdata_q(cfg_rdata_q));

  pch_config_header pch_config_header_i (.clk(clk), .resetn(resetn), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_byte_en_n(cfg_byte_en_n),
    .cfg_wdata(cfg_wdata), .cfg_claim_q(cfg_claim_q), .cfg_rdata_q(cfg_rdata_q),
    .in_d0(in_d0), .rom_window_enable(rom_window_enable),
    .pci_command_control(pci_command_control), .io_claim_en_q(io_claim_en_q),
    .mem_claim_en_q(mem_claim_en_q), .rom_decode_en_q(rom_decode_en_q),
    .cis_access(cis_access), .cis_retry_q(cis_retry_q), .pcix_mode(pcix_mode),
    .master_req(master_req), .master_split(master_split), .mwi_wanted(mwi_wanted),
    .master_go_q(master_go_q), .mwi_select_q(mwi_select_q), .parity_event(parity_event),
    .system_fault_event(system_fault_event), .parity_report_q(parity_report_q),
    .serr_out_q(serr_out_q), .serr_oe_q(serr_oe_q));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Command write through a config cycle
  task automatic set_cmd(input logic [15:0] v);
    pch_host_model_i.cfg_access(1'b1, 8'h04, 4'h0, {16'h0, v}, cl, rd);
  endtask

  // Counts and verdict, ends the run
  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    results();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    // Table of plain accesses, command all zero at first
    for (int i = 0; i < NROWS; i++) begin
      pch_host_model_i.cfg_access(rows[i].wr, rows[i].addr, rows[i].ben, rows[i].wd, cl, rd);
      chk("cfg_claim_q", 32'h1, 32'(cl));
      chk("cfg_rdata_q", rows[i].exp_rd, rd);
      chk("pci_command_control", 32'(rows[i].exp_cmd), 32'(pci_command_control));
    end
    // Card info pointer fields
    pch_host_model_i.cfg_access(1'b0, 8'h28, 4'h0, 32'h0, cl, rd);
    chk("info_space_select", 32'h2, 32'(rd[2:0]));
    chk("info_byte_offset", 32'h100, 32'(rd[27:3]));
    chk("option_image_index", 32'h0, 32'(rd[31:28]));
    // Back-to-back reads
    pch_host_model_i.cfg_read_pair(8'h34, 8'h28, cl, rd, cl2, rd2);
    chk("pair first", 32'h50, rd);
    chk("pair second", 32'h802, rd2);
    chk("pair claim", 32'h1, 32'(cl2));
    // Every mix of io, mem, master, mwi, D0 and ROM window enable
    for (int k = 0; k < 64; k++) begin
      kv = k[5:0];
      set_cmd({11'h0, kv[3], 1'b0, kv[2:0]});
      in_d0 = kv[4];
      rom_window_enable = kv[5];
      @(negedge clk);
      master_req = 1'b1;
      mwi_wanted = 1'b1;
      cis_access = 1'b1;
      @(negedge clk);
      chk("io_claim_en_q", 32'(kv[0] & kv[4]), 32'(io_claim_en_q));
      chk("mem_claim_en_q", 32'(kv[1] & kv[4]), 32'(mem_claim_en_q));
      chk("rom_decode_en_q", 32'(kv[1] & kv[5] & kv[4]), 32'(rom_decode_en_q));
      chk("master_go_q", 32'(kv[2] & kv[4]), 32'(master_go_q));
      chk("mwi_select_q", 32'(kv[2] & kv[4] & kv[3]), 32'(mwi_select_q));
      chk("cis_retry_q", 32'(kv[1] & kv[4]), 32'(cis_retry_q));
      master_req = 1'b0;
      mwi_wanted = 1'b0;
      cis_access = 1'b0;
    end
    // Split completion in PCI-X mode with mastering disabled
    set_cmd(16'h0000);
    pcix_mode = 1'b1;
    master_split = 1'b1;
    @(negedge clk);
    master_req = 1'b1;
    @(negedge clk);
    chk("split go", 32'h1, 32'(master_go_q));
    master_split = 1'b0;
    @(negedge clk);
    chk("non-split go", 32'h0, 32'(master_go_q));
    master_req = 1'b0;
    pcix_mode = 1'b0;
    // Parity reaction and system error gating
    for (int j = 0; j < 4; j++) begin
      set_cmd({7'h0, j[1], 1'b0, j[0], 6'h0});
      @(negedge clk);
      parity_event = 1'b1;
      system_fault_event = 1'b1;
      @(negedge clk);
      chk("parity_report_q", 32'(j[0]), 32'(parity_report_q));
      chk("serr_oe_q", 32'(j[1]), 32'(serr_oe_q));
      chk("serr_out_q", 32'h0, 32'(serr_out_q));
      parity_event = 1'b0;
      system_fault_event = 1'b0;
      @(negedge clk);
      chk("serr_oe_q idle", 32'h0, 32'(serr_oe_q));
      chk("parity_report_q idle", 32'h0, 32'(parity_report_q));
    end
    // Reset in mid-run clears the command register
    set_cmd(16'h0157);
    in_d0 = 1'b1;
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    chk("cmd in reset", 32'h0, 32'(pci_command_control));
    chk("io in reset", 32'h0, 32'(io_claim_en_q));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    pch_host_model_i.cfg_access(1'b0, 8'h04, 4'h0, 32'h0, cl, rd);
    chk("cmd after reset", 32'h0, rd);
    results();
  end
endmodule
`default_nettype wire

/* File: pch_enable_gate.sv */
// Purpose: Registered qualifiers derived from command bits and power state
// Assumes: D0 and ROM window enable come from logic on the same clock
// Notes: One cycle of latency from a command change to the qualifiers
`timescale 1ns/1ns
`default_nettype none
module pch_enable_gate
  import pch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Qualifier sources
  input wire logic [15:0] cmd,
  input wire logic in_d0,
  input wire logic rom_window_enable,
  // Registered qualifiers
  output logic io_claim_en_q,
  output logic mem_claim_en_q,
  output logic rom_decode_en_q,
  output logic initiator_en_q
);

  // ---------------------------------------------------------------
  // Qualifier registers
  // ---------------------------------------------------------------
  // Decode enables follow command bits gated by D0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_claim_en_q <= 1'b0;
      mem_claim_en_q <= 1'b0;
      rom_decode_en_q <= 1'b0;
      initiator_en_q <= 1'b0;
    end else begin
      io_claim_en_q <= cmd[PCH_CMD_IO] & in_d0;
      mem_claim_en_q <= cmd[PCH_CMD_MEM] & in_d0;
      rom_decode_en_q <= cmd[PCH_CMD_MEM] & rom_window_enable & in_d0;
      initiator_en_q <= cmd[PCH_CMD_MASTER] & in_d0;
    end
  end

endmodule
`default_nettype wire

/* File: pch_host_model.sv */
// Purpose: Host bridge model issuing configuration data phases
// Assumes: Requests change on the falling edge, device answers one edge later
// Notes: Released request lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module pch_host_model (
  // Clock
  input wire logic clk,
  // Configuration request
  output var logic cfg_valid,
  output var logic cfg_write,
  output var logic [7:0] cfg_addr,
  output var logic [3:0] cfg_byte_en_n,
  output var logic [31:0] cfg_wdata,
  // Device answer
  input wire logic cfg_claim_q,
  input wire logic [31:0] cfg_rdata_q
);
  // ------------------------------------------------------------
  // Request driving
  // ------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    cfg_valid = 1'b0;
    cfg_write = 1'b1;
    cfg_addr = 8'hff;
    cfg_byte_en_n = 4'hf;
    cfg_wdata = 32'hffffffff;
  end

  // Present one IDSEL-qualified data phase
  task automatic drive(input logic wr, input logic [7:0] a, input logic [3:0] ben,
                       input logic [31:0] wd);
    cfg_valid = 1'b1;
    cfg_write = wr;
    cfg_addr = a;
    cfg_byte_en_n = ben;
    cfg_wdata = wd;
  endtask

  // Drop the request, leaving no stale values on the lines
  task automatic release_bus;
    cfg_valid = 1'b0;
    cfg_write = ~cfg_write;
    cfg_addr = ~cfg_addr;
    cfg_byte_en_n = ~cfg_byte_en_n;
    cfg_wdata = ~cfg_wdata;
  endtask

  // Single access, answer taken one cycle after the request
  task automatic cfg_access(input logic wr, input logic [7:0] a, input logic [3:0] ben,
                            input logic [31:0] wd, output logic cl, output logic [31:0] rd);
    @(negedge clk);
    drive(wr, a, ben, wd);
    @(negedge clk);
    cl = cfg_claim_q;
    rd = cfg_rdata_q;
    release_bus();
  endtask

  // Two reads on consecutive cycles
  task automatic cfg_read_pair(input logic [7:0] a0, input logic [7:0] a1,
                               output logic cl0, output logic [31:0] rd0,
                               output logic cl1, output logic [31:0] rd1);
    @(negedge clk);
    drive(1'b0, a0, 4'h0, 32'h0);
    @(negedge clk);
    cl0 = cfg_claim_q;
    rd0 = cfg_rdata_q;
    drive(1'b0, a1, 4'h0, 32'h0);
    @(negedge clk);
    cl1 = cfg_claim_q;
    rd1 = cfg_rdata_q;
    release_bus();
  endtask
endmodule
`default_nettype wire

/* File: pch_pkg.sv */
// Purpose: Shared constants for the PCI configuration header register block
// Assumes: Byte addresses within the 256-byte configuration space
// Notes: Fixed header values and command bit positions live here only
package pch_pkg;

  // ---------------------------------------------------------------
  // Configuration space byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PCH_OFF_CMD = 8'h04;
  localparam logic [7:0] PCH_OFF_CLASS = 8'h08;
  localparam logic [7:0] PCH_OFF_CIS = 8'h28;
  localparam logic [7:0] PCH_OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] PCH_OFF_CAP_ID = 8'h50;

  // ---------------------------------------------------------------
  // Fixed header values
  // ---------------------------------------------------------------
  localparam logic [7:0] PCH_CAP_ID_VAL = 8'h01;
  localparam logic [7:0] PCH_CAP_PTR_VAL = 8'h50;
  localparam logic [23:0] PCH_CLASS_VAL = 24'h020000;
  localparam logic [7:0] PCH_REVISION_VAL = 8'h00; // Arbitrary value

  // ---------------------------------------------------------------
  // Card information pointer fields
  // ---------------------------------------------------------------
  localparam int PCH_CIS_SPACE_LSB = 0;
  localparam int PCH_CIS_OFFSET_LSB = 3;
  localparam int PCH_CIS_IMAGE_LSB = 28;
  localparam logic [2:0] PCH_CIS_SPACE_VAL = 3'h2;
  localparam logic [24:0] PCH_CIS_OFFSET_VAL = 25'h0000100;
  localparam logic [3:0] PCH_CIS_IMAGE_VAL = 4'h0;
  localparam logic [31:0] PCH_CIS_VAL = 32'h00000802;

  // ---------------------------------------------------------------
  // Command register layout
  // ---------------------------------------------------------------
  localparam int PCH_CMD_IO = 0;
  localparam int PCH_CMD_MEM = 1;
  localparam int PCH_CMD_MASTER = 2;
  localparam int PCH_CMD_MWI = 4;
  localparam int PCH_CMD_PERR = 6;
  localparam int PCH_CMD_SERR = 8;
  localparam logic [15:0] PCH_CMD_WR_MASK = 16'h0157;
  localparam logic [15:0] PCH_CMD_RESET = 16'h0000;

endpackage
